// ==== l1ms_pkg.sv ====
// l1ms_pkg: codes and constants of the level 1 memory subsystem
// assumes: compiled before l1ms_top; the testbench also depends on it
package l1ms_pkg;
  // ------------------------------------------------------------
  // core request codes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_LOAD     = 2'b00,
    OP_STORE    = 2'b01,
    OP_INV_LINE = 2'b10,
    OP_INV_ALL  = 2'b11
  } l1ms_op_e;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  // ------------------------------------------------------------
  // state codes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    C_IDLE = 2'b00,
    C_STEP = 2'b01,
    C_FILL = 2'b10,
    C_DONE = 2'b11
  } l1ms_cst_e;
  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_EXT  = 2'b01,
    D_TCMW = 2'b10
  } l1ms_dst_e;
  typedef enum logic [1:0] {
    X_WB   = 2'b00,
    X_FILL = 2'b01,
    X_DMA  = 2'b10
  } l1ms_own_e;
  // ------------------------------------------------------------
  // sizes and reset values
  // ------------------------------------------------------------
  localparam int unsigned LINES_DEF     = 16;
  localparam int unsigned TCM_BYTES_DEF = 1024;
  localparam int unsigned DMA_LEN_W     = 16;
  localparam logic [31:0] TCM_BASE_DEF  = 32'h1000_0000;
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
endpackage : l1ms_pkg

// ==== l1ms_top.sv ====
// l1ms_top: level 1 memory subsystem, byte-stepped cache, tightly
// coupled memory, one-entry write buffer and a two-channel dma engine
// assumes: core holds a request until ack; an mmu outside supplies the
// physical address with every virtual one; external port acks once
// Behaviour
// - a byte address picks the same byte in either endian mode
// - unaligned word and halfword accesses complete correctly
// - cache behaves physically tagged; remaps need no software cleaning
// - virtual aliases of one physical location stay coherent
// - cache organisation split or unified, visible to the coprocessor; here always one array, UNIFIED only sets the reported bit
// - split caches need no hardware instruction/data coherency
// - cache maintenance takes virtual addresses as operands
// - close level 2 cache controlled via coprocessor, address kind free
// - memory-mapped level 2 cache control uses physical addresses
// - buffered writes abort precisely only for faults seen at entry
// - faults found draining the write buffer raise an imprecise abort
// - tightly coupled memory physical, banks in disjoint ranges
// - tightly coupled memory split or unified like the cache; here always one unified array
// - writes to tightly coupled memory make no external write
// - a location sits in tightly coupled memory or cache, never both
// - only core and dma reach tightly coupled memory; dma in registers
// - at most two dma channels, chainable one after another
// - dma and cache-mode use of the memory never active together
module l1ms_top #(
  parameter int unsigned LINES     = l1ms_pkg::LINES_DEF,
  parameter int unsigned TCM_BYTES = l1ms_pkg::TCM_BYTES_DEF,
  parameter logic [31:0] TCM_BASE  = l1ms_pkg::TCM_BASE_DEF,
  parameter bit          UNIFIED   = 1'b1,
  parameter bit          L2_MMAP   = 1'b1
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_reset_n,
  input  wire logic                 i_core_req,
  input  wire l1ms_pkg::l1ms_op_e   i_core_op,
  input  wire logic [1:0]           i_core_size,
  input  wire logic [31:0]          i_core_vaddr,
  input  wire logic [31:0]          i_core_paddr,
  input  wire logic [31:0]          i_core_wdata,
  input  wire logic                 i_core_xlat_fault,
  input  wire logic                 i_big_endian,
  output logic                      o_core_ack,
  output logic                      o_core_abort,
  output logic [31:0]               o_core_rdata,
  output logic                      o_imprecise_abort,
  output logic                      o_l2_maint,
  output logic [31:0]               o_l2_maint_addr,
  output logic                      o_cache_unified,
  output logic                      o_ext_req,
  output logic                      o_ext_we,
  output logic [31:0]               o_ext_addr,
  output logic [31:0]               o_ext_wdata,
  output logic [3:0]                o_ext_be,
  input  wire logic                 i_ext_ack,
  input  wire logic [31:0]          i_ext_rdata,
  input  wire logic                 i_ext_err,
  input  wire logic                 i_dma_cfg_we,
  input  wire logic                 i_dma_cfg_ch,
  input  wire logic [31:0]          i_dma_cfg_ext,
  input  wire logic [31:0]          i_dma_cfg_tcm,
  input  wire logic [15:0]          i_dma_cfg_len,
  input  wire logic                 i_dma_cfg_to_tcm,
  input  wire logic                 i_dma_cfg_chain,
  input  wire logic                 i_dma_start,
  input  wire logic                 i_cache_mode_en,
  output logic [1:0]                o_dma_busy,
  output logic                      o_dma_err
);
  localparam int unsigned IW = $clog2(LINES);
  localparam int unsigned TW = $clog2(TCM_BYTES);
  localparam int unsigned GW = 30 - IW;
  localparam logic [31:0] TCM_SIZE = 32'(TCM_BYTES);

  // base aligned to a power-of-two size keeps the bank range disjoint
  if (LINES < 2 || (LINES & (LINES - 1)) != 0) begin : g_chk_lines
    $error("LINES must be a power of two, at least 2");
  end
  if (TCM_BYTES < 4 || (TCM_BYTES & (TCM_BYTES - 1)) != 0 ||
      (TCM_BASE & (TCM_SIZE - 32'h1)) != 32'h0) begin : g_chk_tcm
    $error("TCM_BYTES must be a power of two and TCM_BASE aligned");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  l1ms_pkg::l1ms_cst_e cst_q, cst_d;
  l1ms_pkg::l1ms_op_e  op_q, op_d;
  l1ms_pkg::l1ms_dst_e dst_q, dst_d;
  l1ms_pkg::l1ms_own_e own_q, own_d;
  logic [1:0]          cnt_q, cnt_d, last_q, last_d;
  logic [31:0]         pa_q, pa_d, wd_q, wd_d, rd_q, rd_d, l2a_q, l2a_d;
  logic                big_q, big_d, ack_q, ack_d, abt_q, abt_d;
  logic                l2v_q, l2v_d, impr_q, impr_d;
  logic [LINES-1:0]    cv_q, cv_d;
  logic                wb_v_q, wb_v_d;
  logic [31:0]         wb_a_q, wb_a_d;
  logic [7:0]          wb_b_q, wb_b_d;
  logic                xb_q, xb_d, xwe_q, xwe_d;
  logic [31:0]         xa_q, xa_d, xwd_q, xwd_d;
  logic [3:0]          xbe_q, xbe_d;
  logic [1:0][31:0]    dext_q, dext_d;
  logic [1:0][TW-1:0]  dtcm_q, dtcm_d;
  logic [1:0][15:0]    dlen_q, dlen_d;
  logic [1:0]          dto_q, dto_d, dchn_q, dchn_d, dbsy_q, dbsy_d;
  logic                dcur_q, dcur_d, derr_q, derr_d;
  logic [7:0]          dbyte_q, dbyte_d;

  logic [GW-1:0]       ctag [LINES];
  logic [31:0]         cdat [LINES];
  logic [7:0]          tightly_coupled_memory [TCM_BYTES];

  // ------------------------------------------------------------
  // address decode of the current byte step
  // ------------------------------------------------------------
  logic [31:0] a, off;
  logic [IW-1:0] idx;
  logic [GW-1:0] tag;
  logic [1:0] lane;
  logic in_tcm, hit, st, x_ack, adv, dadv;
  logic [7:0] cbyte, wbyte, tcm_rd, tcm_drd;
  logic c_we, t_cwe, t_dwe, wb_set;
  logic [3:0] c_bm;
  logic [31:0] c_wd;

  assign a      = pa_q + {30'h0, cnt_q};
  assign off    = a - TCM_BASE;
  assign in_tcm = (a >= TCM_BASE) && (off < TCM_SIZE);
  assign idx    = a[2 +: IW];
  assign tag    = a[31 -: GW];
  // physical index and tag: aliases land on one line
  assign hit    = cv_q[idx] && (ctag[idx] == tag);
  assign cbyte  = cdat[idx][{a[1:0], 3'b000} +: 8];
  // byte k of the access is lane k, or lane n-1-k in big endian
  assign lane   = big_q ? (last_q - cnt_q) : cnt_q;
  assign wbyte  = wd_q[{lane, 3'b000} +: 8];
  assign st     = (op_q == l1ms_pkg::OP_STORE);
  assign tcm_rd = tightly_coupled_memory[off[TW-1:0]];
  assign tcm_drd = tightly_coupled_memory[dtcm_q[dcur_q]];
  assign x_ack  = xb_q && i_ext_ack;

  // ------------------------------------------------------------
  // core sequencer
  // ------------------------------------------------------------
  always_comb begin
    cst_d = cst_q; op_d = op_q; cnt_d = cnt_q; last_d = last_q;
    pa_d = pa_q; wd_d = wd_q; rd_d = rd_q; big_d = big_q;
    ack_d = 1'b0; abt_d = 1'b0; l2v_d = 1'b0; l2a_d = l2a_q;
    cv_d = cv_q; c_we = 1'b0; c_bm = 4'h0; c_wd = i_ext_rdata;
    t_cwe = 1'b0; wb_set = 1'b0; adv = 1'b0;
    unique case (cst_q)
      l1ms_pkg::C_IDLE: if (i_core_req) begin
        op_d = i_core_op; pa_d = i_core_paddr; wd_d = i_core_wdata;
        big_d = i_big_endian; cnt_d = 2'h0; rd_d = l1ms_pkg::RST_WORD;
        last_d = (i_core_size == l1ms_pkg::SZ_BYTE) ? 2'h0 :
                 (i_core_size == l1ms_pkg::SZ_HALF) ? 2'h1 : 2'h3;
        if (i_core_xlat_fault) begin  // caught on entry: precise
          abt_d = 1'b1; ack_d = 1'b1; cst_d = l1ms_pkg::C_DONE;
        end else if (i_core_op == l1ms_pkg::OP_INV_LINE) begin
          // operand is the virtual address; mmu supplies its frame
          cv_d[i_core_paddr[2 +: IW]] = 1'b0;
          l2v_d = 1'b1;
          l2a_d = L2_MMAP ? i_core_paddr : i_core_vaddr;
          ack_d = 1'b1; cst_d = l1ms_pkg::C_DONE;
        end else if (i_core_op == l1ms_pkg::OP_INV_ALL) begin
          cv_d = '0; ack_d = 1'b1; cst_d = l1ms_pkg::C_DONE;
        end else begin
          cst_d = l1ms_pkg::C_STEP;
        end
      end
      l1ms_pkg::C_STEP: begin
        // at most one byte a cycle, so any alignment and line crossing works
        if (in_tcm) begin  // bypass cache, never allocate
          t_cwe = st;  // no write buffer entry, no bus write
          if (!st) rd_d[{lane, 3'b000} +: 8] = tcm_rd;
          adv = 1'b1;
        end else if (st) begin
          if (!wb_v_q) begin
            wb_set = 1'b1; adv = 1'b1;
            c_we = hit; c_bm = 4'h1 << a[1:0]; c_wd = {4{wbyte}};
          end
        end else if (hit) begin
          rd_d[{lane, 3'b000} +: 8] = cbyte; adv = 1'b1;
        end else begin
          cst_d = l1ms_pkg::C_FILL;
        end
        if (adv) begin
          cnt_d = cnt_q + 2'h1;
          if (cnt_q == last_q) begin
            ack_d = 1'b1; cst_d = l1ms_pkg::C_DONE;
          end
        end
      end
      l1ms_pkg::C_FILL: if (x_ack && own_q == l1ms_pkg::X_FILL) begin
        if (i_ext_err) begin
          abt_d = 1'b1; ack_d = 1'b1; cst_d = l1ms_pkg::C_DONE;
        end else begin
          c_we = 1'b1; c_bm = 4'hf; cv_d[idx] = 1'b1;
          cst_d = l1ms_pkg::C_STEP;
        end
      end
      l1ms_pkg::C_DONE: cst_d = l1ms_pkg::C_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cst_q <= l1ms_pkg::C_IDLE; op_q <= l1ms_pkg::OP_LOAD;
      cnt_q <= 2'h0; last_q <= 2'h0; big_q <= 1'b0;
      pa_q <= l1ms_pkg::RST_WORD; wd_q <= l1ms_pkg::RST_WORD;
      rd_q <= l1ms_pkg::RST_WORD; l2a_q <= l1ms_pkg::RST_WORD;
      ack_q <= 1'b0; abt_q <= 1'b0; l2v_q <= 1'b0; cv_q <= '0;
    end else begin
      cst_q <= cst_d; op_q <= op_d; cnt_q <= cnt_d; last_q <= last_d;
      big_q <= big_d; pa_q <= pa_d; wd_q <= wd_d; rd_q <= rd_d;
      l2a_q <= l2a_d; ack_q <= ack_d; abt_q <= abt_d; l2v_q <= l2v_d;
      cv_q <= cv_d;
    end
  end

  // ------------------------------------------------------------
  // storage arrays, no reset: contents only trusted when valid
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (c_we) begin
      ctag[idx] <= tag;
      for (int b = 0; b < 4; b++) begin
        if (c_bm[b]) cdat[idx][8*b +: 8] <= c_wd[8*b +: 8];
      end
    end
    // core wins the single write port; dma retries next cycle
    if (t_cwe) tightly_coupled_memory[off[TW-1:0]] <= wbyte;
    else if (t_dwe) tightly_coupled_memory[dtcm_q[dcur_q]] <= dbyte_q;
  end

  // ------------------------------------------------------------
  // write buffer and external port arbiter
  // ------------------------------------------------------------
  always_comb begin
    xb_d = xb_q; own_d = own_q; xwe_d = xwe_q; xa_d = xa_q;
    xwd_d = xwd_q; xbe_d = xbe_q; impr_d = 1'b0;
    wb_v_d = wb_v_q; wb_a_d = wb_a_q; wb_b_d = wb_b_q;
    if (x_ack) begin
      xb_d = 1'b0;
      if (own_q == l1ms_pkg::X_WB) begin
        wb_v_d = 1'b0;
        impr_d = i_ext_err;  // core long gone: imprecise
      end
    end else if (!xb_q) begin
      // buffer drains before a fill, so loads never see stale memory
      if (wb_v_q) begin
        xb_d = 1'b1; own_d = l1ms_pkg::X_WB; xwe_d = 1'b1;
        xa_d = wb_a_q; xwd_d = {4{wb_b_q}}; xbe_d = 4'h1 << wb_a_q[1:0];
      end else if (cst_q == l1ms_pkg::C_FILL) begin
        xb_d = 1'b1; own_d = l1ms_pkg::X_FILL; xwe_d = 1'b0;
        xa_d = {a[31:2], 2'b00}; xbe_d = 4'hf;
      end else if (dst_q == l1ms_pkg::D_EXT) begin
        xb_d = 1'b1; own_d = l1ms_pkg::X_DMA; xwe_d = !dto_q[dcur_q];
        xa_d = dext_q[dcur_q]; xwd_d = {4{tcm_drd}};
        xbe_d = 4'h1 << dext_q[dcur_q][1:0];
      end
    end
    if (wb_set) begin
      wb_v_d = 1'b1; wb_a_d = a; wb_b_d = wbyte;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      xb_q <= 1'b0; own_q <= l1ms_pkg::X_WB; xwe_q <= 1'b0;
      xa_q <= l1ms_pkg::RST_WORD; xwd_q <= l1ms_pkg::RST_WORD;
      xbe_q <= 4'h0; impr_q <= 1'b0; wb_v_q <= 1'b0;
      wb_a_q <= l1ms_pkg::RST_WORD; wb_b_q <= 8'h00;
    end else begin
      xb_q <= xb_d; own_q <= own_d; xwe_q <= xwe_d; xa_q <= xa_d;
      xwd_q <= xwd_d; xbe_q <= xbe_d; impr_q <= impr_d;
      wb_v_q <= wb_v_d; wb_a_q <= wb_a_d; wb_b_q <= wb_b_d;
    end
  end

  // ------------------------------------------------------------
  // dma engine, byte at a time, one channel active
  // ------------------------------------------------------------
  always_comb begin
    dst_d = dst_q; dcur_d = dcur_q; dbsy_d = dbsy_q; dext_d = dext_q;
    dtcm_d = dtcm_q; dlen_d = dlen_q; dto_d = dto_q; dchn_d = dchn_q;
    dbyte_d = dbyte_q; derr_d = 1'b0; t_dwe = 1'b0; dadv = 1'b0;
    if (i_dma_cfg_we && !dbsy_q[i_dma_cfg_ch]) begin
      dext_d[i_dma_cfg_ch] = i_dma_cfg_ext;
      dtcm_d[i_dma_cfg_ch] = i_dma_cfg_tcm[TW-1:0];
      dlen_d[i_dma_cfg_ch] = i_dma_cfg_len;
      dto_d[i_dma_cfg_ch]  = i_dma_cfg_to_tcm;
      dchn_d[i_dma_cfg_ch] = i_dma_cfg_chain;
    end
    if (i_dma_start && !dbsy_q[i_dma_cfg_ch] && !i_cache_mode_en) begin
      dbsy_d[i_dma_cfg_ch] = 1'b1;  // refused in cache mode
    end
    unique case (dst_q)
      l1ms_pkg::D_IDLE: if (!i_cache_mode_en) begin
        if (!dbsy_q[dcur_q]) begin
          if (dbsy_q[~dcur_q]) dcur_d = ~dcur_q;
        end else if (dlen_q[dcur_q] == 16'h0) begin
          dbsy_d[dcur_q] = 1'b0;
          if (dchn_q[dcur_q]) begin  // hand over to the other
            dbsy_d[~dcur_q] = 1'b1; dcur_d = ~dcur_q;
          end
        end else begin
          dst_d = l1ms_pkg::D_EXT;
        end
      end
      l1ms_pkg::D_EXT: if (x_ack && own_q == l1ms_pkg::X_DMA) begin
        if (i_ext_err) begin
          derr_d = 1'b1; dbsy_d[dcur_q] = 1'b0; dst_d = l1ms_pkg::D_IDLE;
        end else if (dto_q[dcur_q]) begin
          dbyte_d = i_ext_rdata[{dext_q[dcur_q][1:0], 3'b000} +: 8];
          dst_d = l1ms_pkg::D_TCMW;
        end else begin
          dadv = 1'b1;
        end
      end
      l1ms_pkg::D_TCMW: if (!t_cwe && !i_cache_mode_en) begin
        t_dwe = 1'b1; dadv = 1'b1;
      end
      default: dst_d = l1ms_pkg::D_IDLE;
    endcase
    if (dadv) begin
      dext_d[dcur_q] = dext_q[dcur_q] + 32'h1;
      dtcm_d[dcur_q] = dtcm_q[dcur_q] + TW'(1);
      dlen_d[dcur_q] = dlen_q[dcur_q] - 16'h1;
      dst_d = l1ms_pkg::D_IDLE;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dst_q <= l1ms_pkg::D_IDLE; dcur_q <= 1'b0; dbsy_q <= 2'h0;
      dext_q <= '0; dtcm_q <= '0; dlen_q <= '0; dto_q <= 2'h0;
      dchn_q <= 2'h0; dbyte_q <= 8'h00; derr_q <= 1'b0;
    end else begin
      dst_q <= dst_d; dcur_q <= dcur_d; dbsy_q <= dbsy_d;
      dext_q <= dext_d; dtcm_q <= dtcm_d; dlen_q <= dlen_d;
      dto_q <= dto_d; dchn_q <= dchn_d; dbyte_q <= dbyte_d;
      derr_q <= derr_d;
    end
  end

  // ------------------------------------------------------------
  // outputs; no i/d coherency logic since one unified cache
  // ------------------------------------------------------------
  logic org_q;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) org_q <= UNIFIED;
    else org_q <= UNIFIED;
  end
  assign o_cache_unified = org_q;
  assign o_core_ack = ack_q;
  assign o_core_abort = abt_q;
  assign o_core_rdata = rd_q;
  assign o_imprecise_abort = impr_q;
  assign o_l2_maint = l2v_q;
  assign o_l2_maint_addr = l2a_q;
  assign o_ext_req = xb_q;
  assign o_ext_we = xwe_q;
  assign o_ext_addr = xa_q;
  assign o_ext_wdata = xwd_q;
  assign o_ext_be = xbe_q;
  assign o_dma_busy = dbsy_q;
  assign o_dma_err = derr_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [31:0] xoff;
  assign xoff = o_ext_addr - TCM_BASE;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  AST_PRECISE: assert property (
    cst_q == l1ms_pkg::C_IDLE && i_core_req && i_core_xlat_fault
    |=> o_core_ack && o_core_abort) else $error("entry fault not precise");
  AST_IMPRECISE: assert property (
    x_ack && own_q == l1ms_pkg::X_WB && i_ext_err
    |=> o_imprecise_abort ##1 !o_imprecise_abort)
    else $error("drain fault not reported");
  AST_TCM_NOEXT: assert property (
    o_ext_req && o_ext_we && own_q == l1ms_pkg::X_WB
    |-> !(o_ext_addr >= TCM_BASE && xoff < TCM_SIZE))
    else $error("external write to tcm range");
  AST_TCM_FIRST: assert property (
    cst_q == l1ms_pkg::C_STEP && in_tcm |=> cst_q != l1ms_pkg::C_FILL)
    else $error("tcm access went to cache fill");
  AST_FILL_PHYS: assert property (
    o_ext_req && own_q == l1ms_pkg::X_FILL
    |-> !o_ext_we && o_ext_addr[31:2] == a[31:2] && !wb_v_q)
    else $error("fill not at physical address");
  AST_INV_ALL: assert property (
    cst_q == l1ms_pkg::C_IDLE && i_core_req && !i_core_xlat_fault &&
    i_core_op == l1ms_pkg::OP_INV_ALL |=> cv_q == '0 ##1
    cst_q == l1ms_pkg::C_IDLE) else $error("invalidate all failed");
  AST_L2_ADDR: assert property (
    o_l2_maint |-> !L2_MMAP || o_l2_maint_addr == $past(i_core_paddr))
    else $error("l2 control not physical");
  AST_SC_EXCL: assert property (
    i_cache_mode_en && dst_q == l1ms_pkg::D_IDLE
    |=> dst_q == l1ms_pkg::D_IDLE) else $error("dma ran in cache mode");
  AST_CHAIN: assert property (
    dst_q == l1ms_pkg::D_IDLE && !i_cache_mode_en && dbsy_q[dcur_q] &&
    dlen_q[dcur_q] == 16'h0 && dchn_q[dcur_q]
    |=> dcur_q != $past(dcur_q) && dbsy_q[dcur_q])
    else $error("chain did not start next channel");
endmodule : l1ms_top

// ==== l1ms_ext_model.sv ====
// l1ms_ext_model: behavioural external memory on the far port
// assumes: one request at a time, fields held until the ack edge
module l1ms_ext_model (
  input  wire logic        i_clk,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic [31:0] i_err_addr,
  input  wire logic [1:0]  i_lat,
  output logic             o_ack,
  output logic [31:0]      o_rdata,
  output logic             o_err,
  output int               o_n_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [int];
  int         wait_q = 0;
  function automatic logic [7:0] rb(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : (a[7:0] ^ 8'h5a);
  endfunction : rb
  initial begin
    o_ack   = 1'b0;
    o_err   = 1'b0;
    o_rdata = 32'h0;
    o_n_wr  = 0;
  end
  // data lines inverted each cycle except on a read ack, so the last word shows every other cycle
  always @(posedge i_clk) begin
    o_ack   <= 1'b0;
    o_err   <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack) begin
      if (wait_q < int'(i_lat)) begin
        wait_q <= wait_q + 1;
      end else begin
        wait_q <= 0;
        o_ack  <= 1'b1;
        o_err  <= (i_addr == i_err_addr);
        if (i_we) begin
          mem[i_addr] = i_wdata[7:0];
          o_n_wr <= o_n_wr + 1;
        end else begin
          for (int k = 0; k < 4; k++) begin
            o_rdata[8*k +: 8] <= rb({i_addr[31:2], 2'h0} + 32'(k));
          end
        end
      end
    end
  end
endmodule : l1ms_ext_model

// ==== testbench.sv ====
// testbench: corner and random tests of l1ms_top against a memory model
// assumes: l1ms_pkg, l1ms_top and l1ms_ext_model compiled before it
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("wrong value at %0t: %h not %h", $time, g, e); \
  end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] TB = l1ms_pkg::TCM_BASE_DEF;
  l1ms_pkg::l1ms_op_e op;
  logic clk, rst_n, req, flt, big, ack, ab, imp, l2m, uni, xq, xw, xk, xe;
  logic cwe, cch, tt, chn, start, sc, derr, s_imp, s_l2, s_derr;
  logic [1:0]  sz, busy, lat;
  logic [3:0]  xbe;
  logic [15:0] clen;
  logic [31:0] va, pa, wd, rd, xa, xd, xr, cext, ctcm, err_a, l2a, l2v, got;
  logic [31:0] rng = 32'h0000_ac98;
  logic [7:0]  rm [int];
  int n_mismatch = 0, total_checks = 0, cyc = 0, n_wr, w0;
  l1ms_top u_l1ms_top (.i_clk(clk), .i_reset_n(rst_n), .i_core_req(req),
    .i_core_op(op), .i_core_size(sz), .i_core_vaddr(va), .i_core_paddr(pa),
    .i_core_wdata(wd), .i_core_xlat_fault(flt), .i_big_endian(big),
    .o_core_ack(ack), .o_core_abort(ab), .o_core_rdata(rd),
    .o_imprecise_abort(imp), .o_l2_maint(l2m), .o_l2_maint_addr(l2a),
    .o_cache_unified(uni), .o_ext_req(xq), .o_ext_we(xw), .o_ext_addr(xa),
    .o_ext_wdata(xd), .o_ext_be(xbe), .i_ext_ack(xk), .i_ext_rdata(xr),
    .i_ext_err(xe), .i_dma_cfg_we(cwe), .i_dma_cfg_ch(cch),
    .i_dma_cfg_ext(cext), .i_dma_cfg_tcm(ctcm), .i_dma_cfg_len(clen),
    .i_dma_cfg_to_tcm(tt), .i_dma_cfg_chain(chn), .i_dma_start(start),
    .i_cache_mode_en(sc), .o_dma_busy(busy), .o_dma_err(derr));
  l1ms_ext_model u_l1ms_ext_model (.i_clk(clk), .i_req(xq), .i_we(xw),
    .i_addr(xa), .i_wdata(xd), .i_err_addr(err_a), .i_lat(lat),
    .o_ack(xk), .o_rdata(xr), .o_err(xe), .o_n_wr(n_wr));
  // ------------------------------------------------------------
  // expectation helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs
  function automatic logic [7:0] rb(input logic [31:0] a);
    return rm.exists(a) ? rm[a] : (a[7:0] ^ 8'h5a);
  endfunction : rb
  function automatic logic [31:0] pack(input logic [31:0] a, input int n);
    logic [31:0] r;
    r = 32'h0;
    for (int k = 0; k < n; k++) r[8*(big ? n-1-k : k) +: 8] = rb(a + k);
    return r;
  endfunction : pack
  // ------------------------------------------------------------
  // core port and dma drivers
  // ------------------------------------------------------------
  task automatic core(input l1ms_pkg::l1ms_op_e o, input logic [1:0] s,
                      input logic [31:0] v, input logic [31:0] p,
                      input logic [31:0] w, input logic f);
    int n;
    n = 0;
    @(posedge clk);
    #2;
    op = o;
    {sz, va, pa, wd, flt, req} = {s, v, p, w, f, 1'b1};
    // look just after the edge, once the registered ack has settled
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (ack !== 1'b1 && n < 300);
    got = rd;
    if (n >= 300) begin
      n_mismatch++;
      results();
    end
    #1 req = 1'b0;
  endtask : core
  task automatic acc(input bit st, input logic [1:0] s,
                     input logic [31:0] v, input logic [31:0] p);
    int n;
    logic [31:0] w, e;
    n = (s == 2'h0) ? 1 : (s == 2'h1) ? 2 : 4;
    w = xs();
    e = pack(p, n);
    core(st ? l1ms_pkg::OP_STORE : l1ms_pkg::OP_LOAD, s, v, p, w, 1'b0);
    `CHK(ab, 1'b0)
    if (st) for (int k = 0; k < n; k++) rm[p+k] = w[8*(big ? n-1-k : k) +: 8];
    else `CHK(got, e)
  endtask : acc
  task automatic cfg(input logic c, input logic [31:0] e,
                     input logic [31:0] t, input logic [15:0] l,
                     input logic h);
    @(posedge clk);
    #2;
    {cwe, cch, cext, ctcm, clen, tt, chn} = {1'b1, c, e, t, l, 1'b1, h};
    for (int k = 0; k < int'(l); k++) rm[TB + t + k] = rb(e + k);
    @(posedge clk);
    #2 cwe = 1'b0;
  endtask : cfg
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // ------------------------------------------------------------
  // clock, watchdog and pulse catchers
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) begin
    cyc++;
    if (imp === 1'b1) s_imp = 1'b1;
    if (derr === 1'b1) s_derr = 1'b1;
    if (xq === 1'b1 && xw === 1'b1) `CHK(xbe, 4'h1 << xa[1:0])
    if (l2m === 1'b1) begin s_l2 = 1'b1; l2v = l2a; end
    if (cyc > 20000) begin n_mismatch++; results(); end
  end
  initial begin
    {rst_n, req, flt, big, cwe, cch, tt, chn, start, sc} = '0;
    op = l1ms_pkg::OP_LOAD;
    {sz, va, pa, wd, cext, ctcm, clen, lat} = '0;
    {s_imp, s_l2, s_derr, err_a} = {3'b000, 32'hffff_fff0};
    repeat (6) @(posedge clk);
    #2 rst_n = 1'b1;
    `CHK(uni, 1'b1)
    // tcm writes stay inside, ext write count untouched
    w0 = n_wr;
    for (int i = 0; i < 16; i++) acc(1, 2'h2, TB ^ 32'h4000_0000, TB + 4*i);
    big = 1'b1;
    acc(1, 2'h2, 32'h7000_0001, TB + 1);
    acc(0, 2'h1, 32'h7000_0003, TB + 3);
    big = 1'b0;
    acc(0, 2'h2, 32'h7000_0002, TB + 2);
    `CHK(n_wr, w0)
    $display("test tcm done");
    // two aliases of one ext location, store between loads
    lat = 2'h3;
    acc(0, 2'h2, 32'h8000_0003, 32'h0200_0003);
    acc(1, 2'h0, 32'h9000_0004, 32'h0200_0004);
    acc(0, 2'h2, 32'h8000_0003, 32'h0200_0003);
    core(l1ms_pkg::OP_LOAD, 2'h2, 32'h0, 32'h0, 32'h0, 1'b1);
    `CHK(ab, 1'b1)
    err_a = 32'h0300_0001;
    acc(1, 2'h0, 32'h8300_0001, 32'h0300_0001);
    repeat (20) @(posedge clk);
    `CHK(s_imp, 1'b1)
    err_a = 32'hffff_fff0;
    core(l1ms_pkg::OP_INV_LINE, 2'h0, 32'h8123_4560, 32'h0123_4560, 32'h0,
         1'b0);
    repeat (3) @(posedge clk);
    `CHK(s_l2, 1'b1)
    `CHK(l2v, 32'h0123_4560)
    core(l1ms_pkg::OP_INV_ALL, 2'h0, 32'h0, 32'h0, 32'h0, 1'b0);
    $display("test ext done");
    // chained dma into tcm, cache-mode refusal, dma read error
    cfg(1'b0, 32'h0400_0000, 32'h100, 16'd3, 1'b1);
    cfg(1'b1, 32'h0400_0010, 32'h200, 16'd2, 1'b0);
    cch = 1'b0;
    start = 1'b1;
    @(posedge clk);
    #2 start = 1'b0;
    @(posedge clk);
    #1 `CHK(busy[0], 1'b1)
    for (int n = 0; n < 400 && busy !== 2'b00; n++) @(posedge clk);
    `CHK(busy, 2'b00)
    acc(0, 2'h1, 32'h7000_0100, TB + 32'h100);
    acc(0, 2'h1, 32'h7000_0200, TB + 32'h200);
    sc = 1'b1;
    start = 1'b1;
    @(posedge clk);
    #2 start = 1'b0;
    repeat (3) @(posedge clk);
    `CHK(busy, 2'b00)
    #2 sc = 1'b0;
    err_a = 32'h0400_0020;
    cfg(1'b0, 32'h0400_0020, 32'h300, 16'd1, 1'b0);
    start = 1'b1;
    @(posedge clk);
    #2 start = 1'b0;
    repeat (20) @(posedge clk);
    `CHK(s_derr, 1'b1)
    `CHK(busy, 2'b00)
    err_a = 32'hffff_fff0;
    $display("test dma done");
    for (int i = 0; i < 60; i++) begin
      lat = 2'(xs());
      big = 1'(xs());
      pa = TB + (xs() & 32'h3b);
      acc(1'(xs()), 2'(xs()), pa ^ 32'h5000_0000, pa);
    end
    $display("test random done");
    results();
  end
endmodule : testbench
